// >>> rtl/rfr_readout.sv
// Purpose: read-out path of an angular-rate sample FIFO over SPI mode 3
// Assumes: cs, sclk, mosi asynchronous to i_mclk (sclk at most mclk/8);
//          sample strobe, mode, trigger and watermark on i_mclk;
//          DEPTH is a power of two
// Notes:   command byte: bit7 read, bit6 auto-increment, bits5:0 address
// Overview of operation
// R1 - enabled FIFO in a non-bypass mode shows its oldest set in 0x28..0x2D
// R2 - each set read shifts out output bytes, pops one slot, reloads outputs
// R3 - thirty two set reads drain a full FIFO; empty reads repeat last set
// R4 - single-byte, six-byte or long burst reads all pop identically
// R5 - burst address increments and wraps from 0x2D back to 0x28
// R6 - host should drain all slots in one burst within one sample period
// R7 - I2C host budgets 29 clocks overhead plus 9 clocks per byte
// R8 - host picks sample rate under 57 Hz at 100 kHz, 228 Hz at 400 kHz
// R9 - fill count rises per stored sample, falls per completed set read
// R10 - stream operation flags overflow when full and overwrites oldest
// R11 - enabled FIFO with bypass mode freezes the output registers
// R12 - a slot is popped only once the last byte of a set is read
// R13 - a sample arriving mid-set stays hidden until the set is finished
`timescale 1ns/100ps
`default_nettype none
`include "rfr_map.svh"
module rfr_readout
#(
   parameter int DEPTH = `RFR_FIFO_DEPTH,
   localparam int AW   = $clog2(DEPTH)
)
(
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_cs_n,
   input  wire logic                 i_sclk,
   input  wire logic                 i_mosi,
   output var  logic                 o_miso,
   output var  logic                 o_miso_oe,
   input  wire logic                 i_sample_valid,
   input  wire rfr_pkg::rfr_sample_t i_sample,
   output var  logic                 o_sample_ready,
   input  wire logic                 i_fifo_enable,
   input  wire logic [2:0]           i_fifo_mode,
   input  wire logic                 i_trigger,
   input  wire logic [4:0]           i_watermark_level,
   output var  logic [AW:0]          o_fifo_fill_count,
   output var  logic                 o_overflow_flag,
   output var  logic                 o_watermark_flag
);

   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   // serial port, sampled on i_mclk
   logic [1:0]          cs_sy_reg;
   logic [2:0]          sclk_sy_reg;
   logic [1:0]          mosi_sy_reg;
   rfr_pkg::rfr_phase_t phase_reg;
   logic [2:0]          bit_cnt_reg;
   logic [6:0]          rx_reg;
   logic                rd_reg;
   logic                inc_reg;
   logic [5:0]          addr_reg;
   logic [7:0]          tx_reg;
   logic                miso_reg;
   logic                oe_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cs_sy_reg   <= 2'h3;
         sclk_sy_reg <= 3'h7;
         mosi_sy_reg <= 2'h0;
      end
      else
      begin
         cs_sy_reg   <= {cs_sy_reg[0], i_cs_n};
         sclk_sy_reg <= {sclk_sy_reg[1:0], i_sclk};
         mosi_sy_reg <= {mosi_sy_reg[0], i_mosi};
      end
   end

   wire       sel      = ~cs_sy_reg[1];
   wire       rise     = sclk_sy_reg[1] & ~sclk_sy_reg[2];
   wire       fall     = ~sclk_sy_reg[1] & sclk_sy_reg[2];
   wire       last_bit = sel & rise & (bit_cnt_reg == 3'h7);
   wire       in_data  = phase_reg == rfr_pkg::PH_DATA;
   wire       cmd_done = last_bit & ~in_data;
   wire       byte_done = last_bit & in_data & rd_reg;
   wire       at_last  = addr_reg == `RFR_OUT_LAST;
   wire       in_block = (addr_reg >= `RFR_OUT_FIRST) & ~(addr_reg > `RFR_OUT_LAST);
   wire [5:0] off      = addr_reg - `RFR_OUT_FIRST;
   wire [5:0] addr_next = ~inc_reg ? addr_reg :
                          at_last  ? `RFR_OUT_FIRST : // R5
                          addr_reg + 6'h01;
   wire       tx_load  = sel & fall & in_data & rd_reg & (bit_cnt_reg == 3'h0);
   wire       tx_shift = sel & fall & in_data & rd_reg;
   logic [47:0] out_bits;
   wire [7:0] rd_byte  = in_block ? out_bits[{off[2:0], 3'h0} +: 8] // R1
                                  : `RFR_UNMAPPED;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase_reg   <= rfr_pkg::PH_CMD;
         bit_cnt_reg <= 3'h0;
         rx_reg      <= 7'h00;
         rd_reg      <= 1'b0;
         inc_reg     <= 1'b0;
         addr_reg    <= 6'h00;
      end
      else if (!sel)
      begin
         phase_reg   <= rfr_pkg::PH_CMD;
         bit_cnt_reg <= 3'h0;
      end
      else if (rise)
      begin
         rx_reg      <= {rx_reg[5:0], mosi_sy_reg[1]};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         case (phase_reg)
            rfr_pkg::PH_CMD:
               if (cmd_done)
               begin
                  phase_reg <= rfr_pkg::PH_DATA;
                  rd_reg    <= rx_reg[6];
                  inc_reg   <= rx_reg[5];
                  addr_reg  <= {rx_reg[4:0], mosi_sy_reg[1]};
               end
            rfr_pkg::PH_DATA:
               if (byte_done)
                  addr_reg <= addr_next; // R5
            default:
               phase_reg <= rfr_pkg::PH_CMD;
         endcase
      end
   end

   // byte is fetched at its first falling edge, late enough to see a reload
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tx_reg   <= 8'h00;
         miso_reg <= 1'b0;
         oe_reg   <= 1'b0;
      end
      else
      begin
         oe_reg <= sel & in_data & rd_reg;
         if (tx_shift)
         begin
            miso_reg <= tx_load ? rd_byte[7] : tx_reg[7]; // R2
            tx_reg   <= {(tx_load ? rd_byte[6:0] : tx_reg[6:0]), 1'b0};
         end
      end
   end

   assign o_miso    = miso_reg;
   assign o_miso_oe = oe_reg;

   // two-entry input buffer
   rfr_pkg::rfr_sample_t buf0_reg;
   rfr_pkg::rfr_sample_t buf1_reg;
   logic [1:0]           bcnt_reg;
   logic                 ready_reg;
   logic                 take;

   wire       in_acc    = i_sample_valid & ready_reg;
   wire       buf_valid = bcnt_reg != 2'h0;
   wire [1:0] bcnt_next = bcnt_reg + {1'b0, in_acc} - {1'b0, take};
   wire rfr_pkg::rfr_sample_t buf0_next =
      (take & (bcnt_reg == 2'h2)) ? buf1_reg :
      (in_acc & ((bcnt_reg == 2'h0) | take)) ? i_sample : buf0_reg;
   wire rfr_pkg::rfr_sample_t buf1_next =
      (in_acc & (bcnt_reg == 2'h1) & ~take) ? i_sample : buf1_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         buf0_reg  <= `RFR_OUT_RST;
         buf1_reg  <= `RFR_OUT_RST;
         bcnt_reg  <= 2'h0;
         ready_reg <= 1'b0;
      end
      else
      begin
         buf0_reg  <= buf0_next;
         buf1_reg  <= buf1_next;
         bcnt_reg  <= bcnt_next;
         ready_reg <= bcnt_next != 2'h2;
      end
   end

   assign o_sample_ready = ready_reg;

   // FIFO control
   logic [AW:0]          count_reg;
   logic [AW-1:0]        rd_ptr_reg;
   logic [AW-1:0]        wr_ptr_reg;
   logic                 ovf_reg;
   logic                 partial_reg;
   logic                 stale_reg;
   logic                 wm_reg;
   rfr_pkg::rfr_sample_t out_reg;
   logic [47:0]          mem_q;

   wire md_fifo   = i_fifo_mode == `RFR_MODE_FIFO;
   wire md_stream = i_fifo_mode == `RFR_MODE_STREAM;
   wire md_s2f    = i_fifo_mode == `RFR_MODE_S2F;
   wire md_b2s    = i_fifo_mode == `RFR_MODE_B2S;
   wire fifo_active = i_fifo_enable & (i_fifo_mode != `RFR_MODE_BYPASS);
   wire en_byp    = i_fifo_enable & ~fifo_active;
   wire s2f_hit   = md_s2f & i_trigger & ovf_reg;
   wire stream_eff = i_fifo_enable &
                     (md_stream | (md_s2f & ~s2f_hit) | (md_b2s & i_trigger));
   wire fifo_eff  = i_fifo_enable & (md_fifo | s2f_hit);
   wire live      = ~i_fifo_enable;
   wire full      = count_reg == FULL_CNT;
   wire pop       = byte_done & at_last & fifo_active & (count_reg != '0); // R12
   assign take    = buf_valid & ~pop & ~(live & partial_reg);
   wire push      = take & (stream_eff | (fifo_eff & ~full));
   wire drop_old  = push & full; // R10
   wire load_fifo = fifo_active & ~partial_reg & ~stale_reg &
                    (count_reg != '0); // R1
   wire load_live = live & take & ~partial_reg; // R13
   wire [AW:0] count_next = count_reg + (AW+1)'(push & ~full) -
                            (AW+1)'(pop); // R9
   wire rfr_pkg::rfr_sample_t out_next =
      load_fifo ? rfr_pkg::rfr_sample_t'(mem_q) :
      load_live ? buf0_reg : out_reg; // R11
   wire partial_next = byte_done ? (in_block & ~at_last) : partial_reg; // R4

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         count_reg  <= '0;
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         ovf_reg    <= 1'b0;
      end
      else if (!fifo_active)
      begin
         count_reg  <= '0;
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         ovf_reg    <= 1'b0;
      end
      else
      begin
         count_reg  <= count_next; // R9
         rd_ptr_reg <= rd_ptr_reg + AW'(pop | drop_old); // R2
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         ovf_reg    <= full | (ovf_reg & ~pop); // R10
      end
   end

   // partial_reg holds the set steady between its first and last byte
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         partial_reg <= 1'b0;
         stale_reg   <= 1'b0;
         wm_reg      <= 1'b0;
         out_reg     <= `RFR_OUT_RST;
      end
      else
      begin
         partial_reg <= partial_next; // R13
         stale_reg   <= pop | push;
         wm_reg      <= count_next > {1'b0, i_watermark_level};
         out_reg     <= out_next; // R3
      end
   end

   assign out_bits          = out_reg;
   assign o_fifo_fill_count = count_reg;
   assign o_overflow_flag   = ovf_reg;
   assign o_watermark_flag  = wm_reg;

   rfr_mem
   #(
      .WIDTH ($bits(rfr_pkg::rfr_sample_t)),
      .DEPTH (DEPTH)
   )
   u_mem
   (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_we    (push),
      .i_waddr (wr_ptr_reg),
      .i_wdata (buf0_reg),
      .i_raddr (rd_ptr_reg),
      .o_rdata (mem_q)
   );

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   a_count_up: assert property // R9
      (push && !full |=> count_reg == $past(count_reg) + 1'b1)
      else $error("fill count did not rise on a stored sample");
   a_count_down: assert property // R9
      (pop |=> count_reg == $past(count_reg) - 1'b1)
      else $error("fill count did not fall on a completed set");
   a_pop_advance: assert property // R2
      (pop |=> rd_ptr_reg == $past(rd_ptr_reg) + 1'b1)
      else $error("read slot did not advance on a set read");
   a_empty_repeat: assert property // R3
      (fifo_active && byte_done && count_reg == '0 |=> $stable(out_reg))
      else $error("empty FIFO read changed the output set");
   a_fill_bound: assert property // R3
      (count_reg <= FULL_CNT)
      else $error("fill count above depth");
   a_addr_wrap: assert property // R5
      (byte_done && at_last && inc_reg |=> addr_reg == `RFR_OUT_FIRST)
      else $error("burst address did not wrap to first output byte");
   a_ovf_set: assert property // R10
      (fifo_active && full |=> ##[0:1] o_overflow_flag)
      else $error("overflow not flagged on full FIFO");
   a_frozen_out: assert property // R11
      (en_byp && $past(en_byp) |-> $stable(out_reg))
      else $error("output set moved while frozen");
   a_set_hold: assert property // R13
      (partial_reg |=> $stable(out_reg))
      else $error("output set changed partway through a set");
   a_pop_whole: assert property // R12
      (pop |-> byte_done && $past(in_data) && in_block)
      else $error("slot popped outside the last output byte");

   c_pop:       cover property (pop && count_reg == FULL_CNT);
   c_overwrite: cover property (drop_old);
   c_buf_full:  cover property (bcnt_reg == 2'h2);
   c_empty_rd:  cover property (byte_done && at_last && fifo_active &&
                                count_reg == '0);

endmodule
`default_nettype wire

// >>> rtl/rfr_map.svh
// Purpose: addresses, field codes and reset values of the rate FIFO read-out
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef RFR_MAP_SVH
`define RFR_MAP_SVH

`define RFR_OUT_FIRST   6'h28
`define RFR_OUT_LAST    6'h2D
`define RFR_FIFO_DEPTH  32
`define RFR_MODE_BYPASS 3'h0
`define RFR_MODE_FIFO   3'h1
`define RFR_MODE_STREAM 3'h2
`define RFR_MODE_S2F    3'h3
`define RFR_MODE_B2S    3'h4
`define RFR_OUT_RST     48'h0
`define RFR_UNMAPPED    8'h00

`endif

// >>> rtl/rfr_pkg.sv
// Purpose: shared types of the rate FIFO read-out
// Assumes: nothing
// Notes:   x sits in the low bits so byte 0 of a set is x low
package rfr_pkg;

   typedef struct packed
   {
      logic [15:0] z;
      logic [15:0] y;
      logic [15:0] x;
   } rfr_sample_t;

   typedef enum logic {PH_CMD, PH_DATA} rfr_phase_t;

endpackage

// >>> rtl/rfr_mem.sv
// Purpose: sample storage, one write port, one registered read port
// Assumes: single clock
// Notes:   a write and a read of the same slot returns the old word
`timescale 1ns/100ps
`default_nettype none
module rfr_mem
#(
   parameter int WIDTH = 48,
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
)
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_we,
   input  wire logic [AW-1:0]    i_waddr,
   input  wire logic [WIDTH-1:0] i_wdata,
   input  wire logic [AW-1:0]    i_raddr,
   output var  logic [WIDTH-1:0] o_rdata
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   always_ff @(posedge i_mclk)
   begin
      if (i_we)
         mem_reg[i_waddr] <= i_wdata;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= '0;
      else
         o_rdata <= mem_reg[i_raddr];
   end

endmodule
`default_nettype wire

// >>> testbench/rfr_spi_host.sv
// Purpose: spi mode 3 host model for the rate fifo read-out
// Assumes: sclk period of eight i_mclk cycles (400 ns)
// Notes:   mosi is inverted on release so a stale bit never looks valid
`timescale 1ns/100ps
`default_nettype none
module rfr_spi_host
(
   input  wire logic i_mclk,
   input  wire logic i_miso,
   output var  logic o_cs_n,
   output var  logic o_sclk,
   output var  logic o_mosi
);
   logic [7:0] rx_buf [0:199];
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
      o_mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   // command byte, then n read bytes in one frame of any length
   task automatic frame(input logic [7:0] cmd, input int n);
      logic [7:0] sh;
      o_cs_n <= 1'b0;
      for (int k = 0; k <= n; k++)
      begin
         sh = (k == 0) ? cmd : 8'hFF;
         for (int b = 7; b >= 0; b--)
         begin
            tick(4);
            o_sclk <= 1'b0;
            o_mosi <= sh[b];
            tick(4);
            o_sclk <= 1'b1;
            if (k > 0)
               rx_buf[k-1][b] = i_miso;
         end
      end
      tick(4);
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi;
      tick(8);
   endtask
endmodule
`default_nettype wire

// >>> testbench/rfr_readout_tb_top.sv
// Purpose: self-checking bench of the rate fifo read-out
// Assumes: spi host model drives the serial port
// Notes:   every sample byte differs so swapped lanes show up
`timescale 1ns/100ps
`default_nettype none
`include "rfr_map.svh"
module rfr_readout_tb_top;
   logic                 clk;
   logic                 rst_n;
   logic                 cs_n;
   logic                 sclk;
   logic                 mosi;
   logic                 miso;
   logic                 miso_oe;
   logic                 sv;
   rfr_pkg::rfr_sample_t smp;
   logic                 rdy;
   logic                 en;
   logic [2:0]           mode;
   logic                 trig;
   logic [4:0]           wm;
   logic [5:0]           fill;
   logic                 ovf;
   logic                 wmf;
   int                   err_total;
   int                   num_checks;

   rfr_readout u_dut
   (
      .i_mclk            (clk),
      .i_rst_n           (rst_n),
      .i_cs_n            (cs_n),
      .i_sclk            (sclk),
      .i_mosi            (mosi),
      .o_miso            (miso),
      .o_miso_oe         (miso_oe),
      .i_sample_valid    (sv),
      .i_sample          (smp),
      .o_sample_ready    (rdy),
      .i_fifo_enable     (en),
      .i_fifo_mode       (mode),
      .i_trigger         (trig),
      .i_watermark_level (wm),
      .o_fifo_fill_count (fill),
      .o_overflow_flag   (ovf),
      .o_watermark_flag  (wmf)
   );
   rfr_spi_host u_host
   (
      .i_mclk (clk),
      .i_miso (miso),
      .o_cs_n (cs_n),
      .o_sclk (sclk),
      .o_mosi (mosi)
   );

   function automatic logic [47:0] smp_of(input int i);
      logic [7:0] v;
      v = i[7:0];
      smp_of = {v + 8'h50, 8'hC5, v + 8'h30, 8'hB3, v + 8'h10, 8'hA1};
   endfunction
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_set(input int off, input int i);
      logic [47:0] got;
      for (int k = 0; k < 6; k++)
         got[8*k+:8] = u_host.rx_buf[off+k];
      chk(got, smp_of(i));
   endtask
   // offer one sample and hold it until the block takes it
   task automatic push(input int i);
      sv <= 1'b1;
      smp <= smp_of(i);
      for (int t = 0; t < 20; t++)
      begin
         @(posedge clk);
         if (rdy === 1'b1)
            break;
      end
      chk(rdy, 1'h1);
      sv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic set_cfg(input logic e, input logic [2:0] m);
      en <= e;
      mode <= m;
      repeat (4) @(posedge clk);
   endtask

   task automatic t_drain;
      set_cfg(1'b1, `RFR_MODE_FIFO);
      for (int i = 0; i < 33; i++)
         push(i);
      chk(fill, 6'h20);
      chk(ovf, 1'h1);
      chk(wmf, 1'h1);
      u_host.frame(8'hE8, 198);
      for (int i = 0; i < 33; i++)
         chk_set(6 * i, (i < 32) ? i : 31);
      chk(fill, 6'h0);
      chk(ovf, 1'h0);
      chk(wmf, 1'h0);
      chk(miso_oe, 1'h0);
   endtask
   task automatic t_single;
      logic [47:0] got;
      push(40);
      push(41);
      for (int a = 0; a < 6; a++)
      begin
         u_host.frame(8'h80 | (8'h28 + a[7:0]), 1);
         got[8*a+:8] = u_host.rx_buf[0];
         chk(fill, (a < 5) ? 6'h2 : 6'h1);
      end
      chk(got, smp_of(40));
      u_host.frame(8'hE8, 6);
      chk_set(0, 41);
   endtask
   task automatic t_midset;
      logic [47:0] e;
      e = smp_of(50);
      push(50);
      u_host.frame(8'hE8, 3);
      push(51);
      chk(fill, 6'h2);
      u_host.frame(8'hEB, 3);
      chk({u_host.rx_buf[2], u_host.rx_buf[1], u_host.rx_buf[0]},
          e[47:24]);
      u_host.frame(8'hE8, 6);
      chk_set(0, 51);
   endtask
   task automatic t_stream;
      set_cfg(1'b1, `RFR_MODE_BYPASS);
      set_cfg(1'b1, `RFR_MODE_STREAM);
      for (int i = 0; i < 34; i++)
         push(i);
      chk(fill, 6'h20);
      chk(ovf, 1'h1);
      u_host.frame(8'hE8, 6);
      chk_set(0, 2);
   endtask
   // trigger held high: stream-to-fifo stops once full,
   // bypass-to-stream keeps overwriting the oldest set
   task automatic t_trig;
      trig <= 1'b1;
      for (int m = 3; m < 5; m++)
      begin
         set_cfg(1'b1, `RFR_MODE_BYPASS);
         set_cfg(1'b1, m[2:0]);
         for (int i = 0; i < 33; i++)
            push(70 + i);
         chk(fill, 6'h20);
         u_host.frame(8'hE8, 6);
         chk_set(0, (m == 3) ? 70 : 71);
      end
      trig <= 1'b0;
   endtask
   // live outputs must not take a new sample in the middle of a set
   task automatic t_frozen;
      logic [47:0] e;
      e = smp_of(60);
      set_cfg(1'b0, `RFR_MODE_BYPASS);
      push(60);
      u_host.frame(8'hE8, 3);
      push(61);
      u_host.frame(8'hEB, 3);
      chk({u_host.rx_buf[2], u_host.rx_buf[1], u_host.rx_buf[0]},
          e[47:24]);
      u_host.frame(8'hE8, 6);
      chk_set(0, 61);
      set_cfg(1'b1, `RFR_MODE_BYPASS);
      push(62);
      u_host.frame(8'hE8, 6);
      chk_set(0, 61);
      chk(fill, 6'h0);
      fork
         u_host.frame(8'h90, 1);
         begin
            repeat (100) @(posedge clk);
            chk(miso_oe, 1'h1);
         end
      join
      chk(u_host.rx_buf[0], `RFR_UNMAPPED);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever
         #25 clk = ~clk;
   end
   // the whole run needs about 0.95 ms of clock
   initial
   begin
      #4000000;
      err_total++;
      summarize;
   end
   initial
   begin
      rst_n = 1'b0;
      sv = 1'b0;
      smp = 48'h0;
      en = 1'b0;
      mode = 3'h0;
      trig = 1'b0;
      wm = 5'h10;
      err_total = 0;
      num_checks = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk({rdy, ovf, wmf, miso_oe, fill}, 10'h200);
      t_drain;
      t_single;
      t_midset;
      t_stream;
      t_trig;
      t_frozen;
      summarize;
   end
endmodule
`default_nettype wire
